// ===== spc_regs.sv
// Double-buffered control registers of the second display plane, with its pixel front end.
// Assumes pipe events and register accesses are synchronous to CLOCK.
//
// Functional notes
// - Pending and active copies, loaded at vblank
// - Surface write or enable rise or fall arms update
// - Disabled pipe applies armed update immediately
// - Enable bit gates pixels and fetching
// - Bit 30 routes pixels through gamma
// - Field 29:26 selects source pixel format
// - Every format converted to ten bits
// - Pipe select reads fixed as pipe B
// - Bit 23 limits keying to overlap when third plane behind
// - Bit 22 makes key matches transparent
// - Field 21:20 selects pixel doubling, alone or with line doubling
// - Bit 15 scans plane rotated 180 degrees
// - Bit 14 selects burst or trickle fetch
// - Bit 13 controls sprite buffer sharing
// - Bit 10 selects linear or X-tiled surface
// - Bit 9 enables asynchronous surface update
// - Surface write flips all pending values, except a register-bus write in asynchronous mode
`timescale 1ns/1ps
`include "spc_cfg.svh"

module spc_regs (
  // Clock, reset and clock enable
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic CE,
  // Register access port
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire spc_pkg::spc_addr_t REG_ADDR,
  input wire spc_pkg::spc_word_t REG_WDATA,
  input wire logic REG_FROM_CS,
  output spc_pkg::spc_word_t REG_RDATA,
  output logic REG_RVALID,
  // Pipe events
  input wire logic PIPE_ENABLED,
  input wire logic VBLANK_START,
  input wire logic TLB_REQ,
  // Source pixels
  input wire logic PIX_IN_VALID,
  input wire logic [63:0] PIX_IN_DATA,
  input wire logic PIX_IN_OVERLAP,
  input wire logic THIRD_PLANE_BEHIND,
  // Active register set
  output spc_pkg::spc_word_t ACT_CONTROL,
  output spc_pkg::spc_word_t ACT_SURFACE,
  output spc_pkg::spc_word_t ACT_PITCH,
  output spc_pkg::spc_word_t SCAN_OFFSET,
  // Decoded plane controls
  output logic FETCH_ENABLE,
  output logic PLANE_BLANK,
  output logic GAMMA_ROUTE,
  output logic DUP_PIXELS,
  output logic DUP_LINES,
  output logic ROTATE_180,
  output logic BURST_FETCH,
  output logic SHARE_SPRITE_BUF,
  output logic TILED_SURFACE,
  output logic UPDATE_ARMED,
  // Pixels toward the blender
  output logic PIX_OUT_VALID,
  output logic [29:0] PIX_OUT_RGB,
  output logic PIX_OUT_TRANSPARENT
);
  import spc_pkg::*;

  // ****************************************
  // State
  // ****************************************
  spc_set_t pend_ff;
  spc_set_t act_ff;
  spc_set_t nxt_act;
  logic armed_ff;
  logic async_pend_ff;
  spc_word_t async_val_ff;
  spc_word_t rdata_ff;
  logic rvalid_ff;
  spc_word_t scan_off_ff;
  logic fetch_en_ff;
  logic blank_ff;
  logic gamma_ff;
  logic dup_pix_ff;
  logic dup_line_ff;
  logic rot_ff;
  logic burst_ff;
  logic share_ff;
  logic tiled_ff;
  logic pix_valid_ff;
  logic [29:0] pix_rgb_ff;
  logic pix_transp_ff;

  // ****************************************
  // Access decode
  // ****************************************
  logic wr_ctl;
  logic wr_surf;
  logic async_mode;
  logic async_wr;
  logic enable_rise;
  logic enable_fall;
  logic trigger;
  logic apply;
  logic async_fire;
  spc_mult_t act_mult;

  assign wr_ctl = REG_WR && REG_ADDR == `SPC_OFF_CONTROL;
  assign wr_surf = REG_WR && REG_ADDR == `SPC_OFF_SURF;
  assign async_mode = act_ff.ctl[`SPC_BIT_ASYNC];
  // Register-bus surface writes bypass the flip while asynchronous mode is active.
  assign async_wr = wr_surf && async_mode && !REG_FROM_CS;
  assign enable_rise = wr_ctl && !pend_ff.ctl[`SPC_BIT_ENABLE] && REG_WDATA[`SPC_BIT_ENABLE];
  // Clearing the enable also arms, so that blanking follows at the next vblank.
  assign enable_fall = wr_ctl && pend_ff.ctl[`SPC_BIT_ENABLE] && !REG_WDATA[`SPC_BIT_ENABLE];
  assign trigger = (wr_surf && !async_wr) || enable_rise || enable_fall;
  assign apply = armed_ff && (VBLANK_START || !PIPE_ENABLED);
  assign async_fire = async_pend_ff && (TLB_REQ || VBLANK_START);

  // ****************************************
  // Pending copy
  // ****************************************
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      pend_ff.ctl <= `SPC_RST_CONTROL;
      pend_ff.linear <= `SPC_RST_ZERO;
      pend_ff.pitch <= `SPC_RST_ZERO;
      pend_ff.keyval <= `SPC_RST_ZERO;
      pend_ff.keymsk <= `SPC_RST_ZERO;
      pend_ff.surf <= `SPC_RST_ZERO;
      pend_ff.tiled <= `SPC_RST_ZERO;
    end else if (CE && REG_WR) begin
      case (REG_ADDR)
        `SPC_OFF_CONTROL: pend_ff.ctl <= REG_WDATA & `SPC_CTL_WMASK;
        `SPC_OFF_LINEAR: pend_ff.linear <= REG_WDATA;
        `SPC_OFF_PITCH: pend_ff.pitch <= REG_WDATA;
        `SPC_OFF_KEYVAL: pend_ff.keyval <= REG_WDATA & `SPC_KEY_WMASK;
        `SPC_OFF_KEYMSK: pend_ff.keymsk <= REG_WDATA & `SPC_KEY_WMASK;
        `SPC_OFF_SURF: pend_ff.surf <= REG_WDATA & `SPC_SURF_WMASK;
        `SPC_OFF_TILED: pend_ff.tiled <= REG_WDATA & `SPC_TILED_WMASK;
        default: pend_ff <= pend_ff;
      endcase
    end
  end

  // ****************************************
  // Update arming
  // ****************************************
  // A trigger in the cycle of an apply keeps the update armed, since the
  // apply copies the values held before that write.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      armed_ff <= 1'b0;
    end else if (CE) begin
      if (trigger) begin
        armed_ff <= 1'b1;
      end else if (apply) begin
        armed_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // Asynchronous surface update
  // ****************************************
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      async_pend_ff <= 1'b0;
      async_val_ff <= `SPC_RST_ZERO;
    end else if (CE) begin
      if (async_wr) begin
        async_pend_ff <= 1'b1;
        async_val_ff <= REG_WDATA & `SPC_SURF_WMASK;
      end else if (async_fire) begin
        async_pend_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // Active copy
  // ****************************************
  always_comb begin
    nxt_act = act_ff;
    if (apply) begin
      nxt_act = pend_ff;
    end
    if (async_fire) begin
      nxt_act.surf = async_val_ff;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      act_ff.ctl <= `SPC_RST_CONTROL;
      act_ff.linear <= `SPC_RST_ZERO;
      act_ff.pitch <= `SPC_RST_ZERO;
      act_ff.keyval <= `SPC_RST_ZERO;
      act_ff.keymsk <= `SPC_RST_ZERO;
      act_ff.surf <= `SPC_RST_ZERO;
      act_ff.tiled <= `SPC_RST_ZERO;
    end else if (CE) begin
      act_ff <= nxt_act;
    end
  end

  // ****************************************
  // Decoded controls
  // ****************************************
  assign act_mult = spc_mult_t'(nxt_act.ctl[`SPC_MULT_HI:`SPC_MULT_LO]);

  // Decoded flops reset to the idle values of a disabled plane; the first
  // enabled edge after reset reloads them from the active copy, so the
  // multiply decode follows the reset control word one cycle late.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      fetch_en_ff <= 1'b0;
      blank_ff <= 1'b1;
      gamma_ff <= 1'b0;
      dup_pix_ff <= 1'b0;
      dup_line_ff <= 1'b0;
      rot_ff <= 1'b0;
      burst_ff <= 1'b0;
      share_ff <= 1'b1;
      tiled_ff <= 1'b0;
      scan_off_ff <= `SPC_RST_ZERO;
    end else if (CE) begin
      fetch_en_ff <= nxt_act.ctl[`SPC_BIT_ENABLE];
      blank_ff <= !nxt_act.ctl[`SPC_BIT_ENABLE];
      gamma_ff <= nxt_act.ctl[`SPC_BIT_GAMMA];
      dup_pix_ff <= act_mult == SPC_MULT_LINE_PIX || act_mult == SPC_MULT_PIX;
      dup_line_ff <= act_mult == SPC_MULT_LINE_PIX;
      rot_ff <= nxt_act.ctl[`SPC_BIT_ROTATE];
      burst_ff <= nxt_act.ctl[`SPC_BIT_BURST];
      share_ff <= !nxt_act.ctl[`SPC_BIT_NOSHARE];
      tiled_ff <= nxt_act.ctl[`SPC_BIT_TILED];
      // Tiled surfaces take the packed x/y offset, linear ones the byte offset.
      scan_off_ff <= nxt_act.ctl[`SPC_BIT_TILED] ? nxt_act.tiled : nxt_act.linear;
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  // Reads return the pending copy, so software sees its own writes before
  // the flip; the pipe select always reads as the fixed assignment.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= `SPC_RST_ZERO;
    end else if (CE) begin
      rvalid_ff <= REG_RD;
      if (REG_RD) begin
        case (REG_ADDR)
          `SPC_OFF_CONTROL: begin
            rdata_ff <= pend_ff.ctl;
            rdata_ff[`SPC_PIPE_HI:`SPC_PIPE_LO] <= `SPC_PIPE_SEL;
          end
          `SPC_OFF_LINEAR: rdata_ff <= pend_ff.linear;
          `SPC_OFF_PITCH: rdata_ff <= pend_ff.pitch;
          `SPC_OFF_KEYVAL: rdata_ff <= pend_ff.keyval;
          `SPC_OFF_KEYMSK: rdata_ff <= pend_ff.keymsk;
          `SPC_OFF_SURF: rdata_ff <= pend_ff.surf;
          `SPC_OFF_TILED: rdata_ff <= pend_ff.tiled;
          default: rdata_ff <= `SPC_RST_ZERO;
        endcase
      end
    end
  end

  // ****************************************
  // Pixel path
  // ****************************************
  spc_pix_if pix ();

  assign pix.raw = PIX_IN_DATA;
  assign pix.fmt = act_ff.ctl[`SPC_FMT_HI:`SPC_FMT_LO];
  assign pix.key = act_ff.keyval[23:0];
  assign pix.mask = act_ff.keymsk[23:0];

  spc_pixconv u_conv (
    .pix(pix)
  );

  spc_keymatch u_match (
    .pix(pix)
  );

  logic key_area;
  logic transparent;

  // The window limit only holds when the third plane is enabled and behind.
  assign key_area = !act_ff.ctl[`SPC_BIT_KEYWIN] || !THIRD_PLANE_BEHIND || PIX_IN_OVERLAP;
  assign transparent = act_ff.ctl[`SPC_BIT_KEYEN] && pix.hit && key_area;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      pix_valid_ff <= 1'b0;
      pix_rgb_ff <= 30'h0;
      pix_transp_ff <= 1'b0;
    end else if (CE) begin
      pix_valid_ff <= PIX_IN_VALID && act_ff.ctl[`SPC_BIT_ENABLE];
      pix_rgb_ff <= pix.rgb;
      pix_transp_ff <= transparent;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb begin
    ACT_CONTROL = act_ff.ctl;
    ACT_CONTROL[`SPC_PIPE_HI:`SPC_PIPE_LO] = `SPC_PIPE_SEL;
  end

  assign ACT_SURFACE = act_ff.surf;
  assign ACT_PITCH = act_ff.pitch;
  assign SCAN_OFFSET = scan_off_ff;
  assign FETCH_ENABLE = fetch_en_ff;
  assign PLANE_BLANK = blank_ff;
  assign GAMMA_ROUTE = gamma_ff;
  assign DUP_PIXELS = dup_pix_ff;
  assign DUP_LINES = dup_line_ff;
  assign ROTATE_180 = rot_ff;
  assign BURST_FETCH = burst_ff;
  assign SHARE_SPRITE_BUF = share_ff;
  assign TILED_SURFACE = tiled_ff;
  assign UPDATE_ARMED = armed_ff;
  assign REG_RDATA = rdata_ff;
  assign REG_RVALID = rvalid_ff;
  assign PIX_OUT_VALID = pix_valid_ff;
  assign PIX_OUT_RGB = pix_rgb_ff;
  assign PIX_OUT_TRANSPARENT = pix_transp_ff;

endmodule

// ===== spc_cfg.svh
// Offsets, field positions, write masks and reset values of the second plane control registers.
// Assumes inclusion by bare name from the package and the design modules; definitions only.
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define SPC_OFF_CONTROL 20'h71180
`define SPC_OFF_LINEAR 20'h71184
`define SPC_OFF_PITCH 20'h71188
`define SPC_OFF_KEYVAL 20'h71194
`define SPC_OFF_KEYMSK 20'h71198
`define SPC_OFF_SURF 20'h7119c
`define SPC_OFF_TILED 20'h711a4

// ****************************************
// Control word field positions
// ****************************************
`define SPC_BIT_ENABLE 31
`define SPC_BIT_GAMMA 30
`define SPC_FMT_HI 29
`define SPC_FMT_LO 26
`define SPC_PIPE_HI 25
`define SPC_PIPE_LO 24
`define SPC_BIT_KEYWIN 23
`define SPC_BIT_KEYEN 22
`define SPC_MULT_HI 21
`define SPC_MULT_LO 20
`define SPC_BIT_ROTATE 15
`define SPC_BIT_BURST 14
`define SPC_BIT_NOSHARE 13
`define SPC_BIT_TILED 10
`define SPC_BIT_ASYNC 9

// ****************************************
// Write masks, fixed fields and reset values
// ****************************************
`define SPC_CTL_WMASK 32'hfcf0e600
`define SPC_KEY_WMASK 32'h00ffffff
`define SPC_SURF_WMASK 32'h1ffff000
`define SPC_TILED_WMASK 32'h0fff0fff
`define SPC_PIPE_SEL 2'h1
`define SPC_RST_CONTROL 32'h00100000
`define SPC_RST_ZERO 32'h00000000

`endif

// ===== spc_pkg.sv
// Types shared by the second plane control block and its pixel helpers.
// Assumes the constants header is on the include path.
`include "spc_cfg.svh"

package spc_pkg;

  typedef logic [19:0] spc_addr_t;
  typedef logic [31:0] spc_word_t;

  // Source pixel formats; every other code is reserved.
  typedef enum logic [3:0] {
    SPC_FMT_IDX8 = 4'h2,
    SPC_FMT_565 = 4'h5,
    SPC_FMT_BGRX8 = 4'h6,
    SPC_FMT_RGBX10 = 4'h8,
    SPC_FMT_BGRX10 = 4'ha,
    SPC_FMT_HALF = 4'hc,
    SPC_FMT_RGBX8 = 4'he
  } spc_fmt_t;

  // Pixel multiply codes.
  typedef enum logic [1:0] {
    SPC_MULT_NONE = 2'h0,
    SPC_MULT_LINE_PIX = 2'h1,
    SPC_MULT_RSVD = 2'h2,
    SPC_MULT_PIX = 2'h3
  } spc_mult_t;

  // One complete copy of the plane registers.
  typedef struct packed {
    spc_word_t ctl;
    spc_word_t linear;
    spc_word_t pitch;
    spc_word_t keyval;
    spc_word_t keymsk;
    spc_word_t surf;
    spc_word_t tiled;
  } spc_set_t;

endpackage

// ===== spc_pix_if.sv
// Pixel carrier between the control block and its converter and key matcher.
// Assumes the owner drives raw data, format, key and mask combinationally.
`timescale 1ns/1ps

interface spc_pix_if;
  logic [63:0] raw;
  logic [3:0] fmt;
  logic [29:0] rgb;
  logic [23:0] key;
  logic [23:0] mask;
  logic hit;

  modport owner (output raw, output fmt, output key, output mask, input rgb, input hit);
  modport conv (input raw, input fmt, output rgb);
  modport match (input rgb, input key, input mask, output hit);
endinterface

// ===== spc_pixconv.sv
// Converts one source pixel to 10 bits per component, packed red, green, blue.
// Assumes raw data is right aligned; reserved formats give black.
`timescale 1ns/1ps

module spc_pixconv (
  spc_pix_if.conv pix
);
  import spc_pkg::*;

  // Half float to unsigned 10-bit fraction; negatives clamp to 0, one and above to full scale.
  function automatic logic [9:0] half_to_10(input logic [15:0] h);
    logic [4:0] e;
    logic [10:0] m;
    begin
      e = h[14:10];
      m = {1'b1, h[9:0]};
      if (h[15] || e == 5'h00) begin
        half_to_10 = 10'h000;
      end else if (e >= 5'h0f) begin
        half_to_10 = 10'h3ff;
      end else begin
        half_to_10 = m[10:1] >> (5'h0e - e);
      end
    end
  endfunction

  always_comb begin
    case (pix.fmt)
      SPC_FMT_IDX8: pix.rgb = {3{pix.raw[7:0], 2'h0}};
      SPC_FMT_565: pix.rgb = {pix.raw[15:11], pix.raw[15:11], pix.raw[10:5], pix.raw[10:7],
                              pix.raw[4:0], pix.raw[4:0]};
      SPC_FMT_BGRX8: pix.rgb = {pix.raw[23:16], pix.raw[23:22], pix.raw[15:8], pix.raw[15:14],
                                pix.raw[7:0], pix.raw[7:6]};
      SPC_FMT_RGBX10: pix.rgb = {pix.raw[9:0], pix.raw[19:10], pix.raw[29:20]};
      SPC_FMT_BGRX10: pix.rgb = {pix.raw[29:20], pix.raw[19:10], pix.raw[9:0]};
      SPC_FMT_HALF: pix.rgb = {half_to_10(pix.raw[15:0]), half_to_10(pix.raw[31:16]),
                               half_to_10(pix.raw[47:32])};
      SPC_FMT_RGBX8: pix.rgb = {pix.raw[7:0], pix.raw[7:6], pix.raw[15:8], pix.raw[15:14],
                                pix.raw[23:16], pix.raw[23:22]};
      default: pix.rgb = 30'h0;
    endcase
  end
endmodule

// ===== spc_keymatch.sv
// Compares the top eight bits of each converted component with the key under the mask.
// Assumes key and mask are packed red, green, blue with eight bits each.
`timescale 1ns/1ps

module spc_keymatch (
  spc_pix_if.match pix
);
  logic [23:0] top8;

  assign top8 = {pix.rgb[29:22], pix.rgb[19:12], pix.rgb[9:2]};
  // A zero mask bit ignores a mismatch in that bit.
  assign pix.hit = ((top8 ^ pix.key) & pix.mask) == 24'h0;
endmodule

// ===== spc_pipe_model.sv
// Pipe model at the far side of the plane: pipe running level, vblank and translation request pulses.
// Assumes the bench asks for a running pipe through run; events move on the falling edge.
`timescale 1ns/1ps

module spc_pipe_model (
  // Clock and pipe request
  input wire logic CLOCK,
  input wire logic run,
  // Pipe events
  output logic PIPE_ENABLED,
  output logic VBLANK_START,
  output logic TLB_REQ
);
  int cnt = 0;

  // A stopped pipe sends no vblank and no translation requests.
  always @(negedge CLOCK) begin
    cnt <= cnt + 1;
    PIPE_ENABLED <= run;
    VBLANK_START <= run && (cnt % 64 == 63);
    TLB_REQ <= run && (cnt % 40 == 17);
  end
endmodule

// ===== spc_regs_asserts.sv
// Checker for the second plane control registers, bound to the top module.
// Assumes a single clock domain and the constants header on the include path.
`timescale 1ns/1ps
`include "spc_cfg.svh"

module spc_regs_asserts (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic CE,
  // Register port and pipe events
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire spc_pkg::spc_addr_t REG_ADDR,
  input wire logic REG_FROM_CS,
  input wire logic REG_RVALID,
  input wire logic PIPE_ENABLED,
  input wire logic VBLANK_START,
  input wire logic PIX_IN_VALID,
  // Outputs watched
  input wire spc_pkg::spc_word_t ACT_CONTROL,
  input wire logic FETCH_ENABLE,
  input wire logic PLANE_BLANK,
  input wire logic GAMMA_ROUTE,
  input wire logic DUP_PIXELS,
  input wire logic DUP_LINES,
  input wire logic TILED_SURFACE,
  input wire logic UPDATE_ARMED,
  input wire logic PIX_OUT_VALID,
  input wire logic PIX_OUT_TRANSPARENT
);
  import spc_pkg::*;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);

  property p_rd_answer; CE && REG_RD |=> REG_RVALID; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_pipe_fixed; ACT_CONTROL[`SPC_PIPE_HI:`SPC_PIPE_LO] == `SPC_PIPE_SEL; endproperty
  a_pipe_fixed: assert property (p_pipe_fixed) else $error("pipe select moved");
  property p_surf_arms;
    CE && REG_WR && REG_ADDR == `SPC_OFF_SURF && (REG_FROM_CS || !ACT_CONTROL[`SPC_BIT_ASYNC]) |=> UPDATE_ARMED;
  endproperty
  a_surf_arms: assert property (p_surf_arms) else $error("surface write did not arm");
  property p_imm_apply; CE && UPDATE_ARMED && !PIPE_ENABLED && !REG_WR |=> !UPDATE_ARMED; endproperty
  a_imm_apply: assert property (p_imm_apply) else $error("stopped pipe update waited");
  property p_vbl_apply; CE && UPDATE_ARMED && VBLANK_START && !REG_WR |=> !UPDATE_ARMED; endproperty
  a_vbl_apply: assert property (p_vbl_apply) else $error("vblank did not apply update");
  property p_act_hold; !UPDATE_ARMED |=> $stable(ACT_CONTROL); endproperty
  a_act_hold: assert property (p_act_hold) else $error("active control moved unarmed");
  property p_enable_dec; FETCH_ENABLE == ACT_CONTROL[31] && PLANE_BLANK != ACT_CONTROL[31]; endproperty
  a_enable_dec: assert property (p_enable_dec) else $error("fetch or blank wrong");
  property p_gamma; GAMMA_ROUTE == ACT_CONTROL[30]; endproperty
  a_gamma: assert property (p_gamma) else $error("gamma route wrong");
  property p_dup;
    !$past(SRST) |-> DUP_LINES == (ACT_CONTROL[21:20] == 2'h1) && DUP_PIXELS == ACT_CONTROL[20];
  endproperty
  a_dup: assert property (p_dup) else $error("duplication decode wrong");
  property p_tiled; TILED_SURFACE == ACT_CONTROL[10]; endproperty
  a_tiled: assert property (p_tiled) else $error("tiling decode wrong");
  property p_pix_valid; CE |=> PIX_OUT_VALID == ($past(PIX_IN_VALID) && $past(FETCH_ENABLE)); endproperty
  a_pix_valid: assert property (p_pix_valid) else $error("pixel valid wrong");
  property p_key_off; CE && !ACT_CONTROL[22] |=> !PIX_OUT_TRANSPARENT; endproperty
  a_key_off: assert property (p_key_off) else $error("transparent without keying");
endmodule

bind spc_regs spc_regs_asserts u_spc_regs_asserts (.CLOCK, .SRST, .CE, .REG_WR, .REG_RD, .REG_ADDR,
  .REG_FROM_CS, .REG_RVALID, .PIPE_ENABLED, .VBLANK_START, .PIX_IN_VALID, .ACT_CONTROL, .FETCH_ENABLE,
  .PLANE_BLANK, .GAMMA_ROUTE, .DUP_PIXELS, .DUP_LINES, .TILED_SURFACE, .UPDATE_ARMED, .PIX_OUT_VALID,
  .PIX_OUT_TRANSPARENT);

// ===== tb_second_plane_control_regs.sv
// Self-checking bench for the second plane control registers with a pipe model.
// Assumes the design, its package, interface and the checker are compiled before it.
`timescale 1ns/1ps
`include "spc_cfg.svh"

module tb_second_plane_control_regs;
  import spc_pkg::*;
  logic CLOCK, SRST, CE, REG_WR, REG_RD, REG_FROM_CS, PIX_IN_VALID, PIX_IN_OVERLAP, THIRD_PLANE_BEHIND, run;
  logic REG_RVALID, PIPE_ENABLED, VBLANK_START, TLB_REQ, FETCH_ENABLE, PLANE_BLANK, GAMMA_ROUTE, DUP_PIXELS;
  logic DUP_LINES, ROTATE_180, BURST_FETCH, SHARE_SPRITE_BUF, TILED_SURFACE, UPDATE_ARMED, PIX_OUT_VALID;
  logic PIX_OUT_TRANSPARENT, key_win;
  logic [63:0] PIX_IN_DATA;
  logic [29:0] PIX_OUT_RGB;
  spc_addr_t REG_ADDR;
  spc_word_t REG_WDATA, REG_RDATA, ACT_CONTROL, ACT_SURFACE, ACT_PITCH, SCAN_OFFSET, d, p;
  spc_word_t w[7];
  spc_addr_t offs[7] = '{`SPC_OFF_CONTROL, `SPC_OFF_LINEAR, `SPC_OFF_PITCH, `SPC_OFF_KEYVAL,
                         `SPC_OFF_KEYMSK, `SPC_OFF_SURF, `SPC_OFF_TILED};
  logic [3:0] fmts[7] = '{4'h2, 4'h5, 4'h6, 4'h8, 4'ha, 4'hc, 4'he};
  int errors, check_count;

  spc_regs u_spc_regs (.CLOCK, .SRST, .CE, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA, .REG_FROM_CS, .REG_RDATA,
    .REG_RVALID, .PIPE_ENABLED, .VBLANK_START, .TLB_REQ, .PIX_IN_VALID, .PIX_IN_DATA, .PIX_IN_OVERLAP,
    .THIRD_PLANE_BEHIND, .ACT_CONTROL, .ACT_SURFACE, .ACT_PITCH, .SCAN_OFFSET, .FETCH_ENABLE, .PLANE_BLANK,
    .GAMMA_ROUTE, .DUP_PIXELS, .DUP_LINES, .ROTATE_180, .BURST_FETCH, .SHARE_SPRITE_BUF, .TILED_SURFACE,
    .UPDATE_ARMED, .PIX_OUT_VALID, .PIX_OUT_RGB, .PIX_OUT_TRANSPARENT);
  spc_pipe_model u_spc_pipe_model (.CLOCK, .run, .PIPE_ENABLED, .VBLANK_START, .TLB_REQ);

  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end

  task automatic chk(string n, logic [63:0] e, logic [63:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(spc_addr_t a, spc_word_t v);
    @(negedge CLOCK);
    REG_WR = 1'b1;
    REG_ADDR = a;
    REG_WDATA = v;
    @(negedge CLOCK);
    REG_WR = 1'b0;
  endtask

  task automatic rd(spc_addr_t a, spc_word_t e, string n);
    @(negedge CLOCK);
    REG_RD = 1'b1;
    REG_ADDR = a;
    @(negedge CLOCK);
    REG_RD = 1'b0;
    chk("read valid", 1, REG_RVALID);
    chk(n, e, REG_RDATA);
  endtask

  // Waits until the armed update has been applied.
  task automatic wait_apply();
    for (int i = 0; i < 300; i++) begin
      @(negedge CLOCK);
      if (UPDATE_ARMED === 1'b0) return;
    end
    errors++;
    $display("BAD update wait expected 0 seen 1");
    tally_and_finish();
  endtask

  // Indexed pixel: every channel carries the index with two low zero bits.
  task automatic pix(logic [7:0] idx);
    @(negedge CLOCK);
    PIX_IN_VALID = 1'b1;
    PIX_IN_DATA = {56'h0, idx};
    PIX_IN_OVERLAP = 1'($urandom);
    @(negedge CLOCK);
    PIX_IN_VALID = 1'b0;
    chk("pix valid", 1, PIX_OUT_VALID);
    chk("pix rgb", {3{idx, 2'b00}}, PIX_OUT_RGB);
    chk("pix key", idx == 8'hab && (!key_win || PIX_IN_OVERLAP), PIX_OUT_TRANSPARENT);
  endtask

  function automatic spc_word_t exp_rd(spc_addr_t a, spc_word_t v);
    case (a)
      `SPC_OFF_CONTROL: return (v & `SPC_CTL_WMASK) | {6'h0, `SPC_PIPE_SEL, 24'h0};
      `SPC_OFF_KEYVAL, `SPC_OFF_KEYMSK: return v & `SPC_KEY_WMASK;
      `SPC_OFF_SURF: return v & `SPC_SURF_WMASK;
      `SPC_OFF_TILED: return v & `SPC_TILED_WMASK;
      `SPC_OFF_LINEAR, `SPC_OFF_PITCH: return v;
      default: return 32'h0;
    endcase
  endfunction

  initial begin
    errors = 0;
    check_count = 0;
    {SRST, CE} = 2'b11;
    {REG_WR, REG_RD, REG_FROM_CS, PIX_IN_VALID, PIX_IN_OVERLAP, THIRD_PLANE_BEHIND, run} = 7'h0;
    REG_ADDR = 20'h0;
    REG_WDATA = 32'h0;
    PIX_IN_DATA = 64'h0;
    key_win = 1'b0;
    d = $urandom(32'ha67e);
    repeat (12) @(negedge CLOCK);
    SRST = 1'b0;
    chk("act ctl rst", exp_rd(`SPC_OFF_CONTROL, `SPC_RST_CONTROL), ACT_CONTROL);
    chk("blank rst", 1, PLANE_BLANK);
    chk("share rst", 1, SHARE_SPRITE_BUF);
    rd(`SPC_OFF_CONTROL, exp_rd(`SPC_OFF_CONTROL, `SPC_RST_CONTROL), "ctl rst");
    for (int i = 1; i < 7; i++) rd(offs[i], 32'h0, "reg rst");
    rd(20'h71190, 32'h0, "unmapped rst");
    $display("reset test done");
    for (int i = 0; i < 7; i++) begin
      d = $urandom & ~32'h80400200;
      w[i] = exp_rd(offs[i], d);
      wr(offs[i], d);
      rd(offs[i], exp_rd(offs[i], d), "reg rw");
    end
    wr(20'h71190, $urandom);
    rd(20'h71190, 32'h0, "unmapped wr");
    chk("act pitch flip", w[2], ACT_PITCH);
    chk("act ctl flip", w[0], ACT_CONTROL);
    chk("act surf flip", w[5], ACT_SURFACE);
    chk("gamma", w[0][30], GAMMA_ROUTE);
    chk("dup pix", w[0][20], DUP_PIXELS);
    chk("dup line", w[0][21:20] == 2'h1, DUP_LINES);
    chk("rotate", w[0][15], ROTATE_180);
    chk("burst", w[0][14], BURST_FETCH);
    chk("share", !w[0][13], SHARE_SPRITE_BUF);
    chk("tiled", w[0][10], TILED_SURFACE);
    chk("scan off", w[0][10] ? 32'h0 : w[1], SCAN_OFFSET);
    $display("register test done");
    foreach (fmts[i]) begin
      wr(`SPC_OFF_CONTROL, {2'b00, fmts[i], 26'h0});
      wr(`SPC_OFF_SURF, $urandom);
      wait_apply();
      chk("act fmt", fmts[i], ACT_CONTROL[29:26]);
    end
    $display("format test done");
    run = 1'b1;
    wr(`SPC_OFF_KEYVAL, 32'h00abab_ab);
    wr(`SPC_OFF_KEYMSK, 32'h00ffffff);
    wr(`SPC_OFF_CONTROL, 32'h88400000);
    wait_apply();
    chk("fetch on", 1, FETCH_ENABLE);
    pix(8'hab);
    repeat (6) pix(8'($urandom));
    $display("pixel test done");
    wr(`SPC_OFF_CONTROL, 32'h88c00000);
    wr(`SPC_OFF_SURF, $urandom);
    wait_apply();
    {THIRD_PLANE_BEHIND, key_win} = 2'b11;
    repeat (6) pix(8'hab);
    {THIRD_PLANE_BEHIND, key_win} = 2'b00;
    $display("key window test done");
    p = $urandom;
    wr(`SPC_OFF_PITCH, p);
    wr(`SPC_OFF_CONTROL, 32'h08400000);
    chk("armed", 1, UPDATE_ARMED);
    chk("fetch held", 1, FETCH_ENABLE);
    chk("pitch held", w[2], ACT_PITCH);
    wait_apply();
    chk("fetch off", 0, FETCH_ENABLE);
    chk("blank on", 1, PLANE_BLANK);
    chk("pitch new", p, ACT_PITCH);
    $display("vblank test done");
    CE = 1'b0;
    wr(`SPC_OFF_PITCH, ~p);
    CE = 1'b1;
    rd(`SPC_OFF_PITCH, p, "ce frozen");
    $display("clock enable test done");
    wr(`SPC_OFF_CONTROL, 32'h88400200);
    wait_apply();
    d = $urandom;
    wr(`SPC_OFF_SURF, d);
    chk("async unarmed", 0, UPDATE_ARMED);
    for (int i = 0; i < 100 && ACT_SURFACE !== (d & `SPC_SURF_WMASK); i++) @(negedge CLOCK);
    chk("async surf", d & `SPC_SURF_WMASK, ACT_SURFACE);
    $display("async test done");
    tally_and_finish();
  end
endmodule
